//--- core/decode_consts.svh
/*
 * Timing, field and selector constants for the opcode decoder.
 * Assumes inclusion by the decoder module only.
 */
// Functional notes
// - Block-of-eight opcodes: register from low bits
// - Absolute jump/call: top opcode bits form page
// - Accumulator loads take one machine cycle
// - Accumulator exchanges take one machine cycle
// - Push/pop: two bytes, two machine cycles
// - Carry/bit clear, set, complement: one cycle
// - AND bit into carry: carry only, two
// - OR bit into carry: carry only, two
// - Bit to carry one; carry to bit two
// - Calls push return, two machine cycles
// - Returns pop PC; interrupt return ends level
// - Long and short jumps take two cycles
// - Carry and zero branches take two cycles
// - Bit-test branches; clear variant clears bit
// - Indirect jump to accumulator plus pointer
// - Compare-and-branch-if-unequal, two cycles
// - Decrement-and-branch-if-nonzero, two cycles
// - Shared opcode chosen by extension select
// - Download stores accumulator, bumps pointer
// - Software break halts into debug state
// - Input-port bits sampled once, stable
// - Machine cycle is two system clocks
`ifndef DECODE_CONSTS_SVH
`define DECODE_CONSTS_SVH
`define MCYC_CLKS 3'h2
`define CNT_W 3
`define REG_LSB 0
`define PAGE_LSB 5
`define EXT_SEL_LSB 4
`define EXT_SEL_DNLD 4'h1
`define EXT_SEL_BRK 4'h2
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`endif

//--- core/decode_pkg.sv
/*
 * Types shared by the opcode decoder and its users.
 * Assumes the constants header sits beside it.
 */
package decode_pkg;
    // Instruction classes the decoder recognises
    typedef enum logic [5:0] {
        c_nop, c_mov_a, c_xch, c_push, c_pop, c_clrc, c_setc, c_cplc,
        c_clrb, c_setb, c_cplb, c_anlc, c_anlnc, c_orlc, c_orlnc, c_movcb,
        c_movbc, c_acall, c_lcall, c_ret, c_reti, c_ajmp, c_ljmp, c_sjmp,
        c_jc, c_jnc, c_jz, c_jnz, c_jb, c_jnb, c_jbc, c_jmpi,
        c_cjne, c_djnz, c_dnld, c_trap, c_other
    } op_class_e;
    // Decoded instruction description
    typedef struct packed {
        op_class_e cls;
        logic [1:0] bytes;
        logic [1:0] mcyc;
        logic [2:0] reg_num;
        logic [2:0] page;
    } dec_s;
    // Instruction bytes as fetched
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
    } fetch_s;
    // Execution outcome handed back to the core
    typedef struct packed {
        logic branch;
        logic [15:0] target;
        logic carry;
        logic carry_wr;
        logic bit_val;
        logic bit_wr;
        logic push_pc;
        logic pop_pc;
        logic int_end;
        logic code_wr;
        logic dptr_inc;
        logic halt;
    } res_s;
endpackage : decode_pkg

//--- core/opcode_decode.sv
/*
 * Opcode decoder and machine-cycle sequencer for an 8-bit core.
 * Assumes the core supplies whole instructions, operand reads and
 * state on the same clock; only the port pin is asynchronous.
 */
`timescale 1ns/1ps
`include "decode_consts.svh"
module opcode_decode
    import decode_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic take_valid,
    output logic take_ready,
    input wire fetch_s fetch,
    input wire logic [15:0] pc_next,
    input wire logic [7:0] acc,
    input wire logic [15:0] dptr,
    input wire logic [15:0] stack_pc,
    input wire logic [7:0] mem_byte,
    input wire logic bit_mem,
    input wire logic bit_is_port,
    input wire logic port_pin,
    input wire logic carry_in,
    input wire logic [7:0] extension_select_register,
    output logic done,
    output dec_s dec_out,
    output res_s res_out
);
    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    logic pin_s1_reg; // First stage, read only by the second
    logic pin_s2_reg; // Safe copy of the port pin
    logic pin_s1_next;
    logic pin_s2_next;

    // Two flops before any logic looks at the pin
    always_comb begin
        pin_s1_next = port_pin;
        pin_s2_next = pin_s1_reg;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
        end
    end

    // ----------------------------------------
    // Decode table
    // ----------------------------------------
    dec_s dec_next_c; // Decode of the offered opcode
    logic [3:0] ext_sel; // Selector for the shared opcode

    assign ext_sel = extension_select_register[`EXT_SEL_LSB +: 4];

    // Class, length and machine cycles per opcode
    always_comb begin
        dec_next_c.cls = c_other;
        dec_next_c.bytes = 2'd1;
        dec_next_c.mcyc = 2'd1;
        dec_next_c.reg_num = fetch.op[`REG_LSB +: 3];
        dec_next_c.page = fetch.op[`PAGE_LSB +: 3];
        if (fetch.op[4:0] == 5'h11) begin
            // Absolute call, page in top bits
            dec_next_c.cls = c_acall;
            dec_next_c.bytes = 2'd2;
            dec_next_c.mcyc = 2'd2;
        end else if (fetch.op[4:0] == 5'h01) begin
            // Absolute jump, page in top bits
            dec_next_c.cls = c_ajmp;
            dec_next_c.bytes = 2'd2;
            dec_next_c.mcyc = 2'd2;
        end else begin
            case (fetch.op)
                8'h00: dec_next_c.cls = c_nop;
                8'he5: begin
                    dec_next_c.cls = c_mov_a;
                    dec_next_c.bytes = 2'd2;
                end
                8'he6, 8'he7: dec_next_c.cls = c_mov_a;
                8'hc5: begin
                    dec_next_c.cls = c_xch;
                    dec_next_c.bytes = 2'd2;
                end
                8'hc6, 8'hc7, 8'hd6, 8'hd7: dec_next_c.cls = c_xch;
                8'hc0, 8'hd0: begin
                    dec_next_c.cls = fetch.op[4] ? c_pop : c_push;
                    dec_next_c.bytes = 2'd2;
                    dec_next_c.mcyc = 2'd2;
                end
                8'hc3: dec_next_c.cls = c_clrc;
                8'hd3: dec_next_c.cls = c_setc;
                8'hb3: dec_next_c.cls = c_cplc;
                8'hc2, 8'hd2, 8'hb2, 8'ha2: begin
                    // One-cycle bit ops with a bit address byte
                    dec_next_c.bytes = 2'd2;
                    case (fetch.op[7:4])
                        4'hc: dec_next_c.cls = c_clrb;
                        4'hd: dec_next_c.cls = c_setb;
                        4'hb: dec_next_c.cls = c_cplb;
                        default: dec_next_c.cls = c_movcb;
                    endcase
                end
                8'h82, 8'hb0, 8'h72, 8'ha0, 8'h92, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70: begin
                    // Two-byte, two-cycle group
                    dec_next_c.bytes = 2'd2;
                    dec_next_c.mcyc = 2'd2;
                    case (fetch.op)
                        8'h82: dec_next_c.cls = c_anlc;
                        8'hb0: dec_next_c.cls = c_anlnc;
                        8'h72: dec_next_c.cls = c_orlc;
                        8'ha0: dec_next_c.cls = c_orlnc;
                        8'h92: dec_next_c.cls = c_movbc;
                        8'h80: dec_next_c.cls = c_sjmp;
                        8'h40: dec_next_c.cls = c_jc;
                        8'h50: dec_next_c.cls = c_jnc;
                        8'h60: dec_next_c.cls = c_jz;
                        default: dec_next_c.cls = c_jnz;
                    endcase
                end
                8'h12, 8'h02, 8'h20, 8'h30, 8'h10, 8'hb5, 8'hb4, 8'hd5: begin
                    // Three-byte, two-cycle group
                    dec_next_c.bytes = 2'd3;
                    dec_next_c.mcyc = 2'd2;
                    case (fetch.op)
                        8'h12: dec_next_c.cls = c_lcall;
                        8'h02: dec_next_c.cls = c_ljmp;
                        8'h20: dec_next_c.cls = c_jb;
                        8'h30: dec_next_c.cls = c_jnb;
                        8'h10: dec_next_c.cls = c_jbc;
                        8'hd5: dec_next_c.cls = c_djnz;
                        default: dec_next_c.cls = c_cjne;
                    endcase
                end
                8'hb6, 8'hb7: begin
                    dec_next_c.cls = c_cjne;
                    dec_next_c.bytes = 2'd3;
                    dec_next_c.mcyc = 2'd2;
                end
                8'h22, 8'h32, 8'h73: begin
                    dec_next_c.mcyc = 2'd2;
                    case (fetch.op)
                        8'h22: dec_next_c.cls = c_ret;
                        8'h32: dec_next_c.cls = c_reti;
                        default: dec_next_c.cls = c_jmpi;
                    endcase
                end
                8'ha5: begin
                    // Shared opcode resolved by the selector nibble
                    if (ext_sel == `EXT_SEL_DNLD) begin
                        dec_next_c.cls = c_dnld;
                        dec_next_c.mcyc = 2'd2;
                    end else if (ext_sel == `EXT_SEL_BRK) begin
                        dec_next_c.cls = c_trap;
                    end else begin
                        dec_next_c.cls = c_other;
                    end
                end
                default: begin
                    // Register blocks of eight
                    case (fetch.op[7:3])
                        5'h1d: dec_next_c.cls = c_mov_a;
                        5'h19: dec_next_c.cls = c_xch;
                        5'h17, 5'h1b: begin
                            dec_next_c.cls = fetch.op[6] ? c_djnz : c_cjne;
                            dec_next_c.bytes = 2'd3; // Both forms carry an operand and an offset byte
                            dec_next_c.mcyc = 2'd2;
                        end
                        default: dec_next_c.cls = c_other;
                    endcase
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outcome at issue
    // ----------------------------------------
    res_s res_next_c; // Outcome of the offered instruction
    logic bit_src; // Tested bit, port bits from the synchronised pin
    logic [15:0] rel_tgt; // Relative target
    logic [7:0] rel_off; // Offset byte position depends on length
    logic [7:0] cmp_a; // Left side of compare
    logic [7:0] dec_val; // Decremented operand

    // A pin read mid-instruction could flip; sample it once at issue
    assign bit_src = bit_is_port ? pin_s2_reg : bit_mem;
    assign rel_off = (dec_next_c.bytes == 2'd3) ? fetch.b2 : fetch.b1;
    assign rel_tgt = pc_next + {{8{rel_off[7]}}, rel_off};
    assign cmp_a = (fetch.op[7:1] == 7'h5a) ? acc : mem_byte;
    assign dec_val = mem_byte - 8'h01;

    // Branch, carry and side effects
    always_comb begin
        res_next_c = '0;
        res_next_c.target = rel_tgt;
        res_next_c.carry = carry_in;
        case (dec_next_c.cls)
            c_clrc, c_setc, c_cplc: begin
                res_next_c.carry_wr = 1'b1;
                res_next_c.carry = (dec_next_c.cls == c_cplc) ? !carry_in : (dec_next_c.cls == c_setc);
            end
            c_clrb, c_setb, c_cplb: begin
                res_next_c.bit_wr = 1'b1;
                res_next_c.bit_val = (dec_next_c.cls == c_cplb) ? !bit_src : (dec_next_c.cls == c_setb);
            end
            c_anlc, c_anlnc: begin
                res_next_c.carry_wr = 1'b1;
                res_next_c.carry = carry_in & (bit_src ^ (dec_next_c.cls == c_anlnc));
            end
            c_orlc, c_orlnc: begin
                res_next_c.carry_wr = 1'b1;
                res_next_c.carry = carry_in | (bit_src ^ (dec_next_c.cls == c_orlnc));
            end
            c_movcb: begin
                res_next_c.carry_wr = 1'b1;
                res_next_c.carry = bit_src;
            end
            c_movbc: begin
                res_next_c.bit_wr = 1'b1;
                res_next_c.bit_val = carry_in;
            end
            c_acall, c_ajmp: begin
                res_next_c.branch = 1'b1;
                res_next_c.push_pc = (dec_next_c.cls == c_acall);
                res_next_c.target = {pc_next[15:11], dec_next_c.page, fetch.b1};
            end
            c_lcall, c_ljmp: begin
                res_next_c.branch = 1'b1;
                res_next_c.push_pc = (dec_next_c.cls == c_lcall);
                res_next_c.target = {fetch.b1, fetch.b2};
            end
            c_ret, c_reti: begin
                res_next_c.branch = 1'b1;
                res_next_c.pop_pc = 1'b1;
                res_next_c.int_end = (dec_next_c.cls == c_reti);
                res_next_c.target = stack_pc;
            end
            c_sjmp: res_next_c.branch = 1'b1;
            c_jc: res_next_c.branch = carry_in;
            c_jnc: res_next_c.branch = !carry_in;
            c_jz: res_next_c.branch = (acc == 8'h00);
            c_jnz: res_next_c.branch = (acc != 8'h00);
            c_jb, c_jbc: begin
                res_next_c.branch = bit_src;
                res_next_c.bit_wr = bit_src && (dec_next_c.cls == c_jbc);
            end
            c_jnb: res_next_c.branch = !bit_src;
            c_jmpi: begin
                res_next_c.branch = 1'b1;
                res_next_c.target = dptr + {8'h00, acc};
            end
            c_cjne: begin
                res_next_c.branch = (cmp_a != ((fetch.op == 8'hb5) ? mem_byte : fetch.b1));
                res_next_c.carry_wr = 1'b1;
                res_next_c.carry = (cmp_a < ((fetch.op == 8'hb5) ? mem_byte : fetch.b1));
            end
            c_djnz: res_next_c.branch = (dec_val != 8'h00);
            c_dnld: begin
                res_next_c.code_wr = 1'b1;
                res_next_c.dptr_inc = 1'b1;
            end
            c_trap: res_next_c.halt = 1'b1;
            default: res_next_c.branch = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Machine-cycle sequencer
    // ----------------------------------------
    typedef enum logic {st_idle, st_exec} seq_e;
    seq_e state_reg; // Sequencer state
    seq_e state_next;
    logic [`CNT_W-1:0] cnt_reg; // Clocks left in the instruction
    logic [`CNT_W-1:0] cnt_next;
    logic done_reg; // Completion pulse
    logic done_next;
    dec_s dec_reg; // Decode of the running instruction
    dec_s dec_next;
    res_s res_reg; // Outcome held for the whole instruction
    res_s res_next;
    logic take; // Instruction accepted this clock

    assign take_ready = (state_reg == st_idle);
    assign take = take_valid && take_ready;

    // Count out mcyc machine cycles of two clocks each
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        dec_next = dec_reg;
        res_next = res_reg;
        case (state_reg)
            st_idle: begin
                if (take) begin
                    state_next = st_exec;
                    // The take clock is the first of the instruction, so done lands on the last one
                    cnt_next = `CNT_W'({1'b0, dec_next_c.mcyc} * `MCYC_CLKS - 3'h2);
                    dec_next = dec_next_c;
                    res_next = res_next_c;
                end
            end
            st_exec: begin
                if (cnt_reg == '0) begin
                    state_next = st_idle;
                    done_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - `CNT_W'(1);
                end
            end
            default: state_next = st_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg <= st_idle;
            cnt_reg <= '0;
            done_reg <= 1'b0;
            dec_reg <= '0;
            res_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            dec_reg <= dec_next;
            res_reg <= res_next;
        end
    end

    assign done = done_reg;
    assign dec_out = dec_reg;
    assign res_out = res_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_one_mc;
        @(posedge clock) disable iff (!rst_b) take && dec_next_c.mcyc == 2'd1 |=> !done_reg ##1 done_reg;
    endproperty
    a_one_mc: assert property (p_one_mc) else $error("one-cycle op not two clocks");
    property p_two_mc;
        @(posedge clock) disable iff (!rst_b) take && dec_next_c.mcyc == 2'd2 |=> !done_reg [*3] ##1 done_reg;
    endproperty
    a_two_mc: assert property (p_two_mc) else $error("two-cycle op not four clocks");
    property p_reg_num;
        @(posedge clock) disable iff (!rst_b) take && fetch.op[7:3] == 5'h1d |=> dec_reg.reg_num == $past(fetch.op[2:0]);
    endproperty
    a_reg_num: assert property (p_reg_num) else $error("register number wrong");
    property p_page;
        @(posedge clock) disable iff (!rst_b) take && fetch.op[3:0] == 4'h1 |=> res_reg.target[10:8] == $past(fetch.op[7:5]);
    endproperty
    a_page: assert property (p_page) else $error("absolute page bits wrong");
    property p_rel;
        @(posedge clock) disable iff (!rst_b) take && fetch.op == 8'h80 |=>
            res_reg.branch && res_reg.target == $past(pc_next) + {{8{$past(fetch.b1[7])}}, $past(fetch.b1)};
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_anl;
        @(posedge clock) disable iff (!rst_b) take && fetch.op == 8'h82 |=>
            res_reg.carry == ($past(carry_in) & $past(bit_src)) && !res_reg.bit_wr;
    endproperty
    a_anl: assert property (p_anl) else $error("carry AND wrong");
    property p_trap;
        @(posedge clock) disable iff (!rst_b) take && fetch.op == 8'ha5 && ext_sel == `EXT_SEL_BRK |=>
            res_reg.halt && dec_reg.mcyc == 2'd1 ##1 done_reg;
    endproperty
    a_trap: assert property (p_trap) else $error("break not one cycle halt");
    property p_dnld;
        @(posedge clock) disable iff (!rst_b) take && fetch.op == 8'ha5 && ext_sel == `EXT_SEL_DNLD |=>
            res_reg.code_wr && res_reg.dptr_inc && dec_reg.mcyc == 2'd2;
    endproperty
    a_dnld: assert property (p_dnld) else $error("download decode wrong");
    property p_hold;
        @(posedge clock) disable iff (!rst_b) state_reg == st_exec |=> $stable(res_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("outcome changed mid-instruction");
    property p_reti;
        @(posedge clock) disable iff (!rst_b) take && fetch.op == 8'h32 |=> res_reg.pop_pc && res_reg.int_end;
    endproperty
    a_reti: assert property (p_reti) else $error("interrupt return wrong");
    c_branch: cover property (@(posedge clock) disable iff (!rst_b) done_reg && res_reg.branch);
    c_port: cover property (@(posedge clock) disable iff (!rst_b) take && bit_is_port && fetch.op == 8'h20);
    c_b2b: cover property (@(posedge clock) disable iff (!rst_b) done_reg && take);
endmodule : opcode_decode

//--- verification/data_mem.sv
/*
 * Data memory model feeding operand bytes and bits to the decoder.
 * Assumes the bench drives the address; contents are fixed at time zero.
 */
`timescale 1ns/1ps
module data_mem (
    input wire logic [7:0] addr,
    output logic [7:0] mem_byte,
    output logic bit_mem
);
    logic [7:0] ram [256]; // Byte store, pattern known to the bench
    // Reads are combinational; bits live in the 20h..2Fh byte range
    always_comb begin
        mem_byte = ram[addr];
        bit_mem = ram[{4'h2, addr[6:3]}][addr[2:0]];
    end
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'(i * 37 + 5);
        end
    end
endmodule : data_mem

//--- verification/tb_opcode_decode.sv
/*
 * Self-checking bench for the opcode decoder: every opcode, with and
 * without pin settling gaps. Assumes the data memory model sits beside it.
 */
`timescale 1ns/1ps
module tb_opcode_decode;
    import decode_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic take_valid = 1'b0, bit_is_port = 1'b0, port_pin = 1'b0, carry_in = 1'b0;
    logic take_ready, done, bit_mem;
    fetch_s fetch = '0;
    logic [15:0] pc_next = 16'h0, dptr = 16'h0, stack_pc = 16'h0;
    logic [7:0] acc = 8'h0, mem_addr = 8'h0, esr = 8'h0, mem_byte;
    dec_s dec_out;
    res_s res_out;
    int checks_done = 0, miscompares = 0, seed = 50721;
    always #12.5 clock = ~clock;
    opcode_decode dut (.clock(clock), .rst_b(rst_b), .take_valid(take_valid), .take_ready(take_ready),
        .fetch(fetch), .pc_next(pc_next), .acc(acc), .dptr(dptr), .stack_pc(stack_pc),
        .mem_byte(mem_byte), .bit_mem(bit_mem), .bit_is_port(bit_is_port), .port_pin(port_pin),
        .carry_in(carry_in), .extension_select_register(esr), .done(done), .dec_out(dec_out),
        .res_out(res_out));
    data_mem mem (.addr(mem_addr), .mem_byte(mem_byte), .bit_mem(bit_mem));
    // ------------------------------------------------------------
    // Compare and finish
    // ------------------------------------------------------------
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------
    // One instruction: drive, model, compare
    // ------------------------------------------------------------
    task automatic run(input logic [7:0] o, input bit gap, input logic [3:0] sel);
        logic [7:0] a, b, m, r;
        logic [15:0] tg;
        logic [31:0] x;
        logic [5:0] f;
        logic c, bv, br, cw, cv, bw, wv, rl;
        int n, by, mc;
        // Pin moves only with settling time, so the synchroniser is flushed
        if (gap) begin
            port_pin <= 1'($random(seed));
            repeat (3) @(posedge clock);
        end
        x = $random(seed);
        a = x[30] ? 8'(x[7:0] * 37 + 5) : x[15:8];
        mem_addr <= x[7:0];
        fetch <= {o, a, x[23:16]};
        acc <= x[31] ? 8'h00 : x[15:8];
        {carry_in, bit_is_port} <= x[25:24];
        {pc_next, dptr} <= $random(seed);
        stack_pc <= 16'($random(seed));
        esr <= {sel, 4'h0};
        take_valid <= 1'b1;
        @(posedge clock);
        take_valid <= 1'b0;
        // Pin flips mid-instruction: the result must not follow it
        if (gap) port_pin <= ~port_pin;
        b = fetch.b2;
        m = mem_byte;
        c = carry_in;
        bv = bit_is_port ? port_pin : bit_mem;
        {by, mc} = {32'd1, 32'd1};
        {br, cw, cv, bw, wv, rl, f, tg} = '0;
        if (o[3:0] == 4'h1) begin
            {by, mc, br, f[5]} = {32'd2, 32'd2, 1'b1, o[4]};
            tg = {pc_next[15:11], o[7:5], a};
        end else case (o) inside
            8'hc3, 8'hd3, 8'hb3: {cw, cv} = {1'b1, o == 8'hd3 | o == 8'hb3 & ~c};
            8'hc2, 8'hd2, 8'hb2: {by, bw, wv} = {32'd2, 1'b1, o == 8'hd2 | o == 8'hb2 & ~bv};
            8'he5, 8'hc5: by = 2;
            8'ha2: {by, cw, cv} = {32'd2, 1'b1, bv};
            8'h92: {by, mc, bw, wv} = {32'd2, 32'd2, 1'b1, c};
            8'h82, 8'hb0, 8'h72, 8'ha0: begin
                {by, mc, cw} = {32'd2, 32'd2, 1'b1};
                cv = o == 8'h82 ? c & bv : o == 8'hb0 ? c & ~bv : o == 8'h72 ? c | bv : c | ~bv;
            end
            8'hc0, 8'hd0: {by, mc} = {32'd2, 32'd2};
            8'h22, 8'h32: {mc, br, tg, f[4], f[3]} = {32'd2, 1'b1, stack_pc, 1'b1, o[4]};
            8'h73: {mc, br, tg} = {32'd2, 1'b1, 16'(acc + dptr)};
            8'h12, 8'h02: {by, mc, br, tg, f[5]} = {32'd3, 32'd2, 1'b1, a, b, o[4]};
            8'h80, 8'h40, 8'h50, 8'h60, 8'h70: begin
                {by, mc, rl} = {32'd2, 32'd2, 1'b1};
                br = o == 8'h80 | o == 8'h40 & c | o == 8'h50 & ~c | o == 8'h60 & acc == 0 | o == 8'h70 & acc != 0;
            end
            8'h10, 8'h20, 8'h30: begin
                {by, mc, rl, br} = {32'd3, 32'd2, 1'b1, (o == 8'h30) ^ bv};
                bw = o == 8'h10 & bv;
            end
            [8'hb4:8'hbf]: begin
                r = o == 8'hb4 ? a : o == 8'hb5 ? m : a;
                r = o == 8'hb5 ? m : r;
                {by, mc, rl, cw} = {32'd3, 32'd2, 1'b1, 1'b1};
                {br, cv} = o < 8'hb6 ? {acc != r, acc < r} : {m != a, m < a};
            end
            8'hd5, [8'hd8:8'hdf]: {by, mc, rl, br} = {32'd3, 32'd2, 1'b1, m != 8'h01};
            8'ha5: {mc, f[2:1], f[0]} = {sel == 1 ? 32'd2 : 32'd1, {2{sel == 4'h1}}, sel == 4'h2};
            default: ;
        endcase
        r = by == 3 ? b : a;
        if (rl) tg = pc_next + {{8{r[7]}}, r};
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n == 1) check(take_ready, 1'b0);
        end while (done !== 1'b1 && n < 10);
        check(n, 48'(2 * mc));
        check({dec_out.bytes, dec_out.mcyc, dec_out.reg_num, dec_out.page},
            {2'(by), 2'(mc), o[2:0], o[7:5]});
        check({res_out.branch, br ? res_out.target : 16'h0, res_out.carry_wr, cw & res_out.carry,
            res_out.bit_wr, bw & res_out.bit_val, res_out.push_pc, res_out.pop_pc, res_out.int_end,
            res_out.code_wr, res_out.dptr_inc, res_out.halt},
            {br, br ? tg : 16'h0, cw, cw & cv, bw, bw & wv, f});
        if (o == 8'ha5) check(dec_out.cls, sel == 1 ? c_dnld : sel == 2 ? c_trap : c_other);
    endtask : run
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        check({done, take_ready, dec_out, res_out}, {2'b01, 43'h0});
        for (int i = 0; i < 512; i++) run(8'(i), i < 256, 4'($random(seed)));
        for (int s = 0; s < 4; s++) run(8'ha5, 1'b0, 4'(s));
        end_of_test();
    end
    initial begin
        #(25 * 10000);
        miscompares++;
        end_of_test();
    end
endmodule : tb_opcode_decode
